// ---- ssc_clkgen.v ----
// Internal serial clock divider for the synchronous serial channel
`timescale 1ns/10ps
module ssc_clkgen (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] divisor,
  input wire run,
  output reg fall_tick,
  output reg rise_tick,
  output reg sclk_out
);
  // Half period counter; each half lasts divisor+1 core clocks
  reg [7:0] cnt_r;

  // Toggle the clock at each half period while running, park high otherwise
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 8'h00;
      sclk_out <= 1'b1;
      fall_tick <= 1'b0;
      rise_tick <= 1'b0;
    end else begin
      fall_tick <= 1'b0;
      rise_tick <= 1'b0;
      if (!run) begin
        // Idle: clock high, counter primed for a full half period
        cnt_r <= 8'h00;
        sclk_out <= 1'b1;
      end else if (cnt_r >= divisor) begin
        cnt_r <= 8'h00;
        sclk_out <= ~sclk_out;
        fall_tick <= sclk_out;
        rise_tick <= ~sclk_out;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule // ssc_clkgen

// ---- ssc_consts.vh ----
// Shared constants for the clocked synchronous serial channel
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH
// Register indices on the plain register port
`define SSC_ADDR_FORMAT 3'h0
`define SSC_ADDR_DIVISOR 3'h1
`define SSC_ADDR_CONTROL 3'h2
`define SSC_ADDR_TXDATA 3'h3
`define SSC_ADDR_FLAGS 3'h4
`define SSC_ADDR_RXDATA 3'h5
// Control register fields
`define SSC_CTL_CKE0 0
`define SSC_CTL_CKE1 1
`define SSC_CTL_TX_DONE_IRQ_ENABLE 2
`define SSC_CTL_MULTIPROC_WAIT_ENABLE 3
`define SSC_CTL_RE 4
`define SSC_CTL_TE 5
`define SSC_CTL_RIE 6
`define SSC_CTL_TIE 7
// Flag register fields
`define SSC_FLG_TX_DONE_FLAG 2
`define SSC_FLG_PER 3
`define SSC_FLG_FER 4
`define SSC_FLG_RX_OVERRUN_FLAG 5
`define SSC_FLG_RX_BUFFER_FULL_FLAG 6
`define SSC_FLG_TX_BUFFER_EMPTY_FLAG 7
// Reset values
`define SSC_RST_FLAGS 8'h84
`define SSC_RST_DIVISOR 8'hFF
// Bits per character
`define SSC_CHAR_BITS 4'h8
`endif

// ---- ssc_core.v ----
// Clocked synchronous serial channel: registers, shifters, serial clock and requests
// How it works
// - Clearing transmit enable empties buffer, resets shifter
// - Clearing receive enable keeps flags and data
// - Pins driven only when selected and enabled; clock pin has no select, driven when enabled and internal
// - Parity or framing fault blocks all transfer
// - Overrun blocks transfer until software clears
// - Receiver syncs to serial clock, initializes
// - Receive bits shift in LSB first
// - Full byte loads holding if buffer empty
// - Error flag stops further full indications
// - Full flag with enable raises full request
// - Any error with enable raises error request
// - Empty request; DMA write clears empty flag
// - Full request; DMA read clears full flag
// - Done flag with enable raises done request
// - Four separate request lines, priority left to controller
// - Data changes on falling, valid on rising
// - Always eight bits, no parity bit
// - Internal clock gives eight pulses, idles high
// - At bit seven reload or set done
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "ssc_consts.vh"
module ssc_core (
  input wire core_clk,
  input wire resetn,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire dma_wr,
  input wire dma_rd,
  input wire pfc_tx_sel,
  input wire pfc_rx_sel,
  input wire sclk_in,
  output wire sclk_out,
  output wire sclk_oe,
  input wire serial_in_pin,
  output wire serial_out_pin,
  output wire serial_out_oe,
  output wire rx_error_irq,
  output wire rx_full_irq,
  output wire tx_empty_irq,
  output wire tx_done_irq
);
  // Software visible registers
  reg [7:0] serial_format_reg_r; // Mode and format, stored only
  reg [7:0] bit_rate_divisor_reg_r; // Internal clock divisor
  reg [7:0] serial_control_reg_r; // Enables and clock source
  reg [7:0] tx_holding_reg_r; // Byte waiting for the transmitter
  reg [7:0] rx_holding_reg_r; // Last byte handed to software
  // Status flags
  reg tx_buffer_empty_flag_r;
  reg tx_done_flag_r;
  reg rx_buffer_full_flag_r;
  reg rx_parity_error_flag_r;
  reg rx_framing_fault_flag_r;
  reg rx_overrun_flag_r;
  // Shifters and state
  reg [7:0] tx_shift_reg_r;
  reg [7:0] rx_shift_reg_r;
  reg [3:0] bit_cnt_r; // Bits left in the current character
  reg busy_r; // A character is on the wire
  reg tx_active_r; // Current character carries transmit data
  reg tx_out_r; // Registered data pin level
  // Pin synchronisers
  reg sclk_s1_r;
  reg sclk_s2_r;
  reg sclk_s3_r; // Previous synchronised level, for edges
  reg sin_s1_r;
  reg sin_s2_r;

  // Control fields
  wire tx_enable = serial_control_reg_r[`SSC_CTL_TE];
  wire rx_enable = serial_control_reg_r[`SSC_CTL_RE];
  wire rx_irq_enable = serial_control_reg_r[`SSC_CTL_RIE];
  wire tx_empty_irq_enable = serial_control_reg_r[`SSC_CTL_TIE];
  wire tx_done_irq_enable = serial_control_reg_r[`SSC_CTL_TX_DONE_IRQ_ENABLE];
  // Only clock enable bit 1 (CKE1) picks the external clock input; bit 0 is ignored
  wire ext_clk = serial_control_reg_r[`SSC_CTL_CKE1];

  // Any pending receive error stops the whole channel
  wire err_any = rx_overrun_flag_r | rx_parity_error_flag_r | rx_framing_fault_flag_r;
  // Parity and framing faults cannot occur in this mode but still block
  wire block_full = rx_parity_error_flag_r | rx_framing_fault_flag_r;

  // Software accesses
  wire wr_flags = reg_wr && (reg_addr == `SSC_ADDR_FLAGS);
  wire wr_tdata = (reg_wr && (reg_addr == `SSC_ADDR_TXDATA)) || dma_wr;
  wire wr_ctl = reg_wr && (reg_addr == `SSC_ADDR_CONTROL);
  wire rd_rdata_dma = dma_rd;
  // Clear-by-write-zero helper: writing 1 leaves a flag alone
  wire clr_tx_buffer_empty_flag = (wr_flags && !reg_wdata[`SSC_FLG_TX_BUFFER_EMPTY_FLAG]) || dma_wr;
  wire clr_rx_buffer_full_flag = (wr_flags && !reg_wdata[`SSC_FLG_RX_BUFFER_FULL_FLAG]) || rd_rdata_dma;
  wire clr_rx_overrun_flag = wr_flags && !reg_wdata[`SSC_FLG_RX_OVERRUN_FLAG];
  wire clr_fer = wr_flags && !reg_wdata[`SSC_FLG_FER];
  wire clr_per = wr_flags && !reg_wdata[`SSC_FLG_PER];
  wire clr_tx_done_flag = wr_flags && !reg_wdata[`SSC_FLG_TX_DONE_FLAG];

  // Start a character: pending data to send, or receiver armed
  wire want_tx = tx_enable && !tx_buffer_empty_flag_r;
  // Receive-only characters need the input pin handed to the channel
  wire can_start = !busy_r && !err_any && (want_tx || (rx_enable && pfc_rx_sel));

  // Internal serial clock runs only while a character is in flight
  wire int_fall;
  wire int_rise;
  wire int_sclk;
  ssc_clkgen u_clkgen (
    .core_clk(core_clk),
    .resetn(resetn),
    .divisor(bit_rate_divisor_reg_r),
    .run(busy_r && !ext_clk),
    .fall_tick(int_fall),
    .rise_tick(int_rise),
    .sclk_out(int_sclk)
  );

  // External clock edges, taken from the synchronised copies only
  wire ext_fall = sclk_s3_r && !sclk_s2_r;
  wire ext_rise = !sclk_s3_r && sclk_s2_r;
  wire fall_ev = ext_clk ? ext_fall : int_fall;
  wire rise_ev = ext_clk ? ext_rise : int_rise;

  // Two flip-flops on every pin input before use
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
      sclk_s3_r <= 1'b1;
      sin_s1_r <= 1'b0;
      sin_s2_r <= 1'b0;
    end else begin
      sclk_s1_r <= sclk_in;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      sin_s1_r <= serial_in_pin;
      sin_s2_r <= sin_s1_r;
    end
  end

  // Configuration registers
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      serial_format_reg_r <= 8'h00;
      bit_rate_divisor_reg_r <= `SSC_RST_DIVISOR;
      serial_control_reg_r <= 8'h00;
      tx_holding_reg_r <= 8'h00;
    end else begin
      if (reg_wr && (reg_addr == `SSC_ADDR_FORMAT))
        serial_format_reg_r <= reg_wdata;
      // Divisor only matters with the internal clock
      if (reg_wr && (reg_addr == `SSC_ADDR_DIVISOR))
        bit_rate_divisor_reg_r <= reg_wdata;
      if (wr_ctl)
        serial_control_reg_r <= reg_wdata;
      // Software or DMA supplies the next byte
      if (wr_tdata)
        tx_holding_reg_r <= dma_wr ? reg_wdata : reg_wdata;
    end
  end

  // Character engine: one shared clock for transmit and receive
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_shift_reg_r <= 8'h00;
      rx_shift_reg_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      busy_r <= 1'b0;
      tx_active_r <= 1'b0;
      tx_out_r <= 1'b1;
      tx_buffer_empty_flag_r <= 1'b1;
      tx_done_flag_r <= 1'b1;
      rx_buffer_full_flag_r <= 1'b0;
      rx_parity_error_flag_r <= 1'b0;
      rx_framing_fault_flag_r <= 1'b0;
      rx_overrun_flag_r <= 1'b0;
      rx_holding_reg_r <= 8'h00;
    end else begin
      // Software clears; hardware sets below win the same cycle
      if (clr_tx_buffer_empty_flag)
        tx_buffer_empty_flag_r <= 1'b0;
      if (clr_rx_buffer_full_flag)
        rx_buffer_full_flag_r <= 1'b0;
      if (clr_rx_overrun_flag)
        rx_overrun_flag_r <= 1'b0;
      if (clr_fer)
        rx_framing_fault_flag_r <= 1'b0;
      if (clr_per)
        rx_parity_error_flag_r <= 1'b0;
      if (clr_tx_done_flag)
        tx_done_flag_r <= 1'b0;
      if (wr_ctl && tx_enable && !reg_wdata[`SSC_CTL_TE]) begin
        // Transmitter reinit; receive flags untouched, character abandoned if RE also cleared
        tx_buffer_empty_flag_r <= 1'b1;
        tx_shift_reg_r <= 8'h00;
        tx_active_r <= 1'b0;
        if (!reg_wdata[`SSC_CTL_RE]) begin
          busy_r <= 1'b0;
          bit_cnt_r <= 4'h0;
        end
      end else if (wr_ctl && !reg_wdata[`SSC_CTL_RE] && !reg_wdata[`SSC_CTL_TE]) begin
        // Receiver off: abandon the character, keep flags and data
        busy_r <= 1'b0;
        bit_cnt_r <= 4'h0;
      end else if (can_start) begin
        // Sync to clock and initialize the shifter state
        busy_r <= 1'b1;
        bit_cnt_r <= `SSC_CHAR_BITS;
        rx_shift_reg_r <= 8'h00;
        tx_active_r <= want_tx;
        if (want_tx) begin
          // Holding byte moves to the shifter; buffer empty again
          tx_shift_reg_r <= tx_holding_reg_r;
          tx_buffer_empty_flag_r <= 1'b1;
          tx_done_flag_r <= 1'b0;
        end
      end else if (busy_r) begin
        if (fall_ev && tx_active_r && bit_cnt_r != 4'h0) begin
          // Present next bit LSB first, from falling edge to falling edge
          tx_out_r <= tx_shift_reg_r[0];
          tx_shift_reg_r <= {1'b0, tx_shift_reg_r[7:1]};
        end
        if (rise_ev) begin
          // Sample on rising edge into the top, ends LSB at bit 0
          rx_shift_reg_r <= {sin_s2_r, rx_shift_reg_r[7:1]};
          bit_cnt_r <= bit_cnt_r - 4'h1;
          if (bit_cnt_r == 4'h1) begin
            busy_r <= 1'b0;
            // Bit seven done: next byte waits in holding, or finish
            if (tx_active_r && !want_tx)
              tx_done_flag_r <= 1'b1;
            if (rx_enable) begin
              if (!rx_buffer_full_flag_r || clr_rx_buffer_full_flag) begin
                if (!block_full) begin
                  rx_holding_reg_r <= {sin_s2_r, rx_shift_reg_r[7:1]};
                  rx_buffer_full_flag_r <= 1'b1;
                end
              end else begin
                rx_overrun_flag_r <= 1'b1;
              end
            end
          end
        end
      end
    end
  end

  // Read port: data one cycle after the strobe, unmapped reads zero
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SSC_ADDR_FORMAT: reg_rdata <= serial_format_reg_r;
        `SSC_ADDR_DIVISOR: reg_rdata <= bit_rate_divisor_reg_r;
        `SSC_ADDR_CONTROL: reg_rdata <= serial_control_reg_r;
        `SSC_ADDR_TXDATA: reg_rdata <= tx_holding_reg_r;
        `SSC_ADDR_FLAGS: reg_rdata <= {tx_buffer_empty_flag_r, rx_buffer_full_flag_r, rx_overrun_flag_r,
                                       rx_framing_fault_flag_r, rx_parity_error_flag_r, tx_done_flag_r, 2'b00};
        `SSC_ADDR_RXDATA: reg_rdata <= rx_holding_reg_r;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Pins: data driven only when selected and enabled; clock driven when enabled and internal, with no select
  assign serial_out_pin = tx_out_r;
  assign serial_out_oe = pfc_tx_sel && tx_enable;
  assign sclk_out = int_sclk;
  assign sclk_oe = !ext_clk && (tx_enable || rx_enable);

  // Four separate level requests, priority left to the controller
  assign rx_error_irq = rx_irq_enable && err_any;
  assign rx_full_irq = rx_irq_enable && rx_buffer_full_flag_r;
  assign tx_empty_irq = tx_empty_irq_enable && tx_buffer_empty_flag_r;
  assign tx_done_irq = tx_done_irq_enable && tx_done_flag_r;
endmodule // ssc_core

// ---- ssc_core_sva.sv ----
// Port-level concurrent checks for the serial channel
`timescale 1ns/10ps
`include "ssc_consts.vh"
module ssc_core_sva (
  input wire core_clk,
  input wire resetn,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire dma_wr,
  input wire dma_rd,
  input wire pfc_tx_sel,
  input wire sclk_out,
  input wire sclk_oe,
  input wire serial_out_pin,
  input wire serial_out_oe,
  input wire rx_error_irq,
  input wire rx_full_irq,
  input wire tx_empty_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Control register write seen on the bus
  wire ctl_wr = reg_wr && (reg_addr == `SSC_ADDR_CONTROL);
  chk_oe_needs_sel: assert property (serial_out_oe |-> pfc_tx_sel)
    else $error("data pin driven without pin select");
  chk_sclk_pulse_end: assert property ($fell(sclk_out) |-> ##[1:600] $rose(sclk_out))
    else $error("serial clock stuck low");
  chk_data_on_fall: assert property (sclk_oe && $past(sclk_oe) && $changed(serial_out_pin) |-> !sclk_out)
    else $error("data changed while serial clock high");
  chk_dma_wr_clear: assert property (dma_wr |=> !tx_empty_irq)
    else $error("empty request stayed after dma write");
  chk_dma_rd_clear: assert property (dma_rd |=> !rx_full_irq)
    else $error("full request stayed after dma read");
  chk_error_blocks: assert property (rx_error_irq |-> sclk_out && $stable(serial_out_pin))
    else $error("transfer ran while error pending");
  chk_te_off_empty: assert property (ctl_wr && !reg_wdata[`SSC_CTL_TE] && reg_wdata[`SSC_CTL_TIE] |=> tx_empty_irq)
    else $error("empty flag not set on transmit disable");
  chk_irq_masked: assert property (ctl_wr && !reg_wdata[`SSC_CTL_RIE] |=> !rx_full_irq && !rx_error_irq)
    else $error("receive request with enable clear");
  chk_rx_keep: assert property (ctl_wr && reg_wdata[`SSC_CTL_RIE] && rx_full_irq |=> rx_full_irq)
    else $error("full flag lost on control write");
  cover property ($rose(rx_full_irq));
  cover property ($rose(rx_error_irq));
  cover property (dma_wr);
endmodule // ssc_core_sva
bind ssc_core ssc_core_sva u_sva (.*);

// ---- ssc_core_tb.sv ----
// Self-checking bench for the serial channel
`timescale 1ns/10ps
module ssc_core_tb;
  reg core_clk = 1'b0;
  reg resetn = 1'b0;
  reg [2:0] reg_addr = 3'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0, reg_rd = 1'b0, dma_wr = 1'b0, dma_rd = 1'b0;
  reg pfc_tx_sel = 1'b1, pfc_rx_sel = 1'b1, ext = 1'b0, go = 1'b0;
  reg [7:0] peer_byte = 8'h00;
  reg [7:0] v;
  wire [7:0] reg_rdata, peer_got;
  wire sclk_out, sclk_oe, serial_out_pin, serial_out_oe, sclk_ext, peer_out;
  wire rx_error_irq, rx_full_irq, tx_empty_irq, tx_done_irq;
  // Shared clock wire: device drives it only while enabled
  wire sclk_in = sclk_oe ? sclk_out : sclk_ext;
  wire serial_in_pin = peer_out;
  // Data line has a pull-up when the device releases it
  wire line_out = serial_out_oe ? serial_out_pin : 1'b1;
  wire [3:0] irqs = {rx_error_irq, rx_full_irq, tx_empty_irq, tx_done_irq};
  int n_fail = 0, n_checks = 0, n_pulse = 0, i;
  // Reset values: address and expected read data
  logic [10:0] rows [4] = '{11'h484, 11'h1FF, 11'h200, 11'h600};
  ssc_core dut (.*);
  ssc_peer peer (.rst_n(resetn), .ext(ext), .go(go), .sck(sclk_in), .data_in(line_out),
    .tx_byte(peer_byte), .sclk_ext(sclk_ext), .data_out(peer_out), .got(peer_got));
  always #2 core_clk = ~core_clk;
  always @(posedge sclk_out) n_pulse++;
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read strobe for one cycle, data taken in the following cycle
  task rd(input [2:0] a, input dm, output [7:0] q);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    dma_rd <= dm;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    dma_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task rc(input [2:0] a, input [7:0] m, input [7:0] e);
    rd(a, 1'b0, v);
    chk(v & m, e);
  endtask
  // Bounded wait on one request line, then let trailing flags settle
  task wt(input int b);
    for (i = 0; i < 3000 && irqs[b] !== 1'b1; i++) @(posedge core_clk);
    if (i == 3000) begin
      n_fail++;
      close_out;
    end
    // Short settle: with receive on, the next character starts at once
    repeat (2) @(posedge core_clk);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    for (int k = 0; k < 4; k++) rc(rows[k][10:8], 8'hFF, rows[k][7:0]);
    wr(1, 8'h03);
    wr(2, 8'h00);
    repeat (8) @(posedge core_clk);
    wr(2, 8'hC4);
    @(posedge core_clk);
    chk({4'h0, irqs}, 8'h03);
    peer_byte <= 8'h5A;
    // Preload while disabled so the first character is full duplex
    wr(3, 8'hA5);
    wr(4, 8'h7F);
    n_pulse = 0;
    wr(2, 8'hF4);
    wt(2);
    chk(peer_got, 8'hA5);
    chk(n_pulse[7:0], 8'h08);
    rc(5, 8'hFF, 8'h5A);
    rc(4, 8'hFF, 8'hC4);
    chk({4'h0, irqs}, 8'h07);
    // Second byte without reading the first: overrun
    peer_byte <= 8'hC3;
    wr(3, 8'h66);
    wr(4, 8'h7F);
    wt(3);
    rc(4, 8'hFF, 8'h64);
    rc(5, 8'hFF, 8'h5A);
    chk(peer_got, 8'hFF);
    // Full cleared but overrun left: nothing may move
    wr(4, 8'hBF);
    peer_byte <= 8'h3C;
    n_pulse = 0;
    @(posedge core_clk);
    dma_wr <= 1'b1;
    reg_wdata <= 8'h96;
    @(posedge core_clk);
    dma_wr <= 1'b0;
    repeat (200) @(posedge core_clk);
    chk(n_pulse[7:0], 8'h00);
    rc(4, 8'hE0, 8'h20);
    wr(4, 8'hDF);
    wt(2);
    chk(peer_got, 8'h96);
    rc(5, 8'hFF, 8'h3C);
    // Abort a frame midway by clearing both enables
    wr(3, 8'h11);
    wr(4, 8'h7F);
    repeat (20) @(posedge core_clk);
    wr(2, 8'hC0);
    rc(4, 8'hC0, 8'hC0);
    rc(5, 8'hFF, 8'h3C);
    chk({7'h00, serial_out_oe}, 8'h00);
    rd(5, 1'b1, v);
    chk(v, 8'h3C);
    rc(4, 8'h40, 8'h00);
    wr(2, 8'h00);
    @(posedge core_clk);
    chk({4'h0, irqs}, 8'h00);
    // Mid-run reset, then receive on the external clock
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    ext <= 1'b1;
    wr(2, 8'h02);
    repeat (40) @(posedge core_clk);
    wr(2, 8'h52);
    peer_byte <= 8'h81;
    go <= 1'b1;
    wt(2);
    rc(5, 8'hFF, 8'h81);
    close_out;
  end
endmodule // ssc_core_tb

// ---- ssc_peer.sv ----
// Remote clocked serial device: shifts bytes both ways, makes clock if external
`timescale 1ns/10ps
module ssc_peer (
  input wire rst_n,
  input wire ext,
  input wire go,
  input wire sck,
  input wire data_in,
  input wire [7:0] tx_byte,
  output reg sclk_ext,
  output reg data_out,
  output reg [7:0] got
);
  reg [2:0] idx;
  initial begin
    sclk_ext = 1'b1;
    data_out = 1'b1;
    got = 8'h00;
  end
  // Eight pulses per frame, clock idles high between frames
  always @(posedge go) begin
    if (ext) begin
      repeat (8) begin
        #62.5 sclk_ext = 1'b0;
        #62.5 sclk_ext = 1'b1;
      end
    end
  end
  // New bit on each falling edge, LSB first
  always @(negedge sck or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 3'h0;
    end else begin
      data_out <= tx_byte[idx];
      idx <= idx + 3'h1;
    end
  end
  // Sample on the rising edge, first bit ends in bit 0
  always @(posedge sck) got <= {data_in, got[7:1]};
endmodule // ssc_peer
